// *** hdl/fpbe_top.sv ***
// fuse protection, key block encoding and program registers on ahb-lite
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps

// Operation
// - mask bit one makes its parameter write-protected, zero leaves it writable.
// - programming only sets bits; ones stay one.
// - protected parameters ignore programming entirely.
// - write protection is permanent once set.
// - one mask bit protects the write-protect mask itself.
// - unguarded parameters readable by software anytime, also used by hardware.
// - read-protect bit one hides parameter from software, hardware still sees it; the status word still shows reserve flag and effective selector.
// - read protection is permanent once set.
// - selector 00/11 none 256, 01 3/4 192, 10 repeat 128.
// - image always 256 bits; no coding copies block bit for bit.
// - 3/4 groups of six bytes copied, byte six is their xor.
// - repeat coding stores 128 bits in both image halves.
// - reserve flag zero leaves selector and key blocks unrestricted.
// - reserve flag one forces 3/4; block three image 191:128 unavailable.
// - every parameter bit maps to exactly one program register bit.
// - word 0 holds write mask, read mask, counter, download disable.
// - read mask bits 0-2 guard key blocks, bit 3 configuration.
module fpbe_top (
  // clock and reset
  input  wire logic         MCLK,
  input  wire logic         RST_N,
  // ahb-lite slave
  input  wire logic         HSEL,
  input  wire logic [8:0]   HADDR,
  input  wire logic [1:0]   HTRANS,
  input  wire logic         HWRITE,
  input  wire logic [2:0]   HSIZE,
  input  wire logic [31:0]  HWDATA,
  input  wire logic         HREADY,
  output logic      [31:0]  HRDATA,
  output logic              HREADYOUT,
  output logic              HRESP,
  // hardware consumers
  output logic      [255:0] KEY_BLOCK_ONE,
  output logic      [255:0] KEY_BLOCK_TWO,
  output logic      [255:0] KEY_BLOCK_THREE,
  output logic      [15:0]  WR_PROT_MASK,
  output logic      [3:0]   RD_PROT_MASK,
  output logic      [1:0]   CODING_SEL
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // bits of a block0 word locked by the write-protect mask
  function automatic logic [31:0] fpbe_blk0(input int w, input logic [15:0] m);
    logic [31:0] b;
    b = '0;
    case (w)
      0:
      begin
        b[15:0]  = {16{m[fpbe_pkg::WP_WRMASK]}};
        b[19:16] = {4{m[fpbe_pkg::WP_RDMASK]}};
        b[26:20] = {7{m[fpbe_pkg::WP_CNT]}};
        b[27]    = m[fpbe_pkg::WP_DLDIS];
      end
      1: b = {32{m[fpbe_pkg::WP_MISC]}};
      2: b[23:0] = {24{m[fpbe_pkg::WP_MISC]}};
      3:
      begin
        b[11:0] = {12{m[fpbe_pkg::WP_MISC]}};
        b[14]   = m[fpbe_pkg::WP_CODE];
      end
      4:
      begin
        b[7:0]   = {8{m[fpbe_pkg::WP_CLK8]}};
        b[16:14] = {3{m[fpbe_pkg::WP_REG]}};
      end
      5:
      begin
        b[19:0]  = {20{m[fpbe_pkg::WP_PAD]}};
        b[27:22] = {6{m[fpbe_pkg::WP_MISC]}};
        b[31:28] = {4{m[fpbe_pkg::WP_CODE]}};
      end
      6:
      begin
        b[1:0] = {2{m[fpbe_pkg::WP_CODE]}};
        b[2]   = m[fpbe_pkg::WP_DBG];
        b[4]   = m[fpbe_pkg::WP_SB0];
        b[5]   = m[fpbe_pkg::WP_SB1];
        b[6]   = m[fpbe_pkg::WP_JTAG];
        b[9:7] = {3{m[fpbe_pkg::WP_DBG]}};
        b[10]  = m[fpbe_pkg::WP_CODE];
      end
      default: b = '0;
    endcase
    return b;
  endfunction : fpbe_blk0

  // bits of a key image word locked by mask or by the reserve flag
  function automatic logic [31:0] fpbe_blkk(input int w, input logic [15:0] m,
                                            input logic res);
    logic [31:0] b;
    int          k;
    k = w / fpbe_pkg::NWB;
    b = {32{m[fpbe_pkg::WP_KEY1 + k]}};
    if (res && (k == 2) && ((w % fpbe_pkg::NWB) == 4 || (w % fpbe_pkg::NWB) == 5))
      b = '1;
    return b;
  endfunction : fpbe_blkk

  // bits of a block0 word hidden from software
  function automatic logic [31:0] fpbe_hide0(input int w, input logic [3:0] r);
    logic [31:0] b;
    b = '0;
    if (w == fpbe_pkg::RES_WORD)
      b[fpbe_pkg::RES_BIT] = r[fpbe_pkg::RP_CFG];
    if (w == 5)
      b[31:28] = {4{r[fpbe_pkg::RP_CFG]}};
    if (w == fpbe_pkg::SCH_WORD)
    begin
      b[1:0] = {2{r[fpbe_pkg::RP_CFG]}};
      b[10]  = r[fpbe_pkg::RP_CFG];
    end
    return b;
  endfunction : fpbe_hide0

  // key block to 256-bit stored image
  function automatic logic [255:0] fpbe_encode(input logic [255:0] d,
                                               input logic [1:0] s,
                                               input logic hold);
    logic [255:0] e;
    logic [7:0]   x;
    logic [7:0]   sum;
    int           i;
    int           j;
    e = d;
    if (s == fpbe_pkg::SCH_REPEAT)
      e = {d[127:0], d[127:0]};
    else if (s == fpbe_pkg::SCH_34)
    begin
      e = '0;
      for (i = 0; i < fpbe_pkg::N_GRP; i++)
      begin
        x   = '0;
        sum = '0;
        for (j = 0; j < fpbe_pkg::N_DBYTE; j++)
        begin
          e[fpbe_pkg::GRP_IBITS*i + fpbe_pkg::BYTE_W*j +: 8] =
            d[fpbe_pkg::GRP_DBITS*i + fpbe_pkg::BYTE_W*j +: 8];
          x   = x ^ d[fpbe_pkg::GRP_DBITS*i + fpbe_pkg::BYTE_W*j +: 8];
          sum = sum + 8'((j + 1) *
                  $countones(d[fpbe_pkg::GRP_DBITS*i + fpbe_pkg::BYTE_W*j +: 8]));
        end
        e[fpbe_pkg::GRP_IBITS*i + fpbe_pkg::BYTE_W*fpbe_pkg::XOR_BYTE +: 8] = x;
        e[fpbe_pkg::GRP_IBITS*i + fpbe_pkg::BYTE_W*fpbe_pkg::SUM_BYTE +: 8] = sum;
      end
      if (hold)
        e[191:128] = '0;
    end
    return e;
  endfunction : fpbe_encode

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [31:0]  prog0_r [0:fpbe_pkg::NW0-1];
  logic [31:0]  progk_r [0:fpbe_pkg::NWK-1];
  logic [31:0]  fuse0_r [0:fpbe_pkg::NW0-1];
  logic [31:0]  fusek_r [0:fpbe_pkg::NWK-1];
  logic [31:0]  raw_r   [0:fpbe_pkg::NWB-1];
  logic [1:0]   enc_sel_r;
  logic [1:0]   eff_sch_r;
  logic         wr_pend_r;
  logic         rd_pend_r;
  logic [6:0]   idx_r;
  logic         hready_r;
  logic [31:0]  hrdata_r;
  logic         hresp_r;
  logic         acc;
  logic         prog_fire;
  logic [15:0]  wmask;
  logic [3:0]   rmask;
  logic         reserve;
  logic [255:0] raw_flat;
  logic [255:0] coded;
  logic [255:0] prog1_flat;
  logic [3:0]   prog_rdm;
  logic [31:0]  rd_val;

  assign acc       = HSEL && HTRANS[1] && HREADY;
  assign wmask     = fuse0_r[0][15:0];
  assign rmask     = fuse0_r[0][19:16];
  assign reserve   = fuse0_r[fpbe_pkg::RES_WORD][fpbe_pkg::RES_BIT];
  assign prog_fire = wr_pend_r && (idx_r == fpbe_pkg::IDX_CMD) &&
                     HWDATA[fpbe_pkg::CMD_PROG_BIT];
  assign prog_rdm  = prog0_r[0][19:16];

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase and ready
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r     <= '0;
      hready_r  <= 1'b1;
      hresp_r   <= 1'b0;
    end
    else
    begin
      wr_pend_r <= acc && HWRITE;
      rd_pend_r <= acc && !HWRITE;
      if (acc)
        idx_r <= HADDR[8:2];
      hready_r  <= !(acc && !HWRITE);
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      hrdata_r <= '0;
    else if (rd_pend_r)
      hrdata_r <= rd_val;
  end

  always_comb
  begin
    rd_val = '0;
    if (idx_r < fpbe_pkg::IDX_PROG0 + 7'(fpbe_pkg::NW0))
      rd_val = prog0_r[3'(idx_r - fpbe_pkg::IDX_PROG0)];
    else if (idx_r >= fpbe_pkg::IDX_PROGK && idx_r < fpbe_pkg::IDX_PROGK + 7'(fpbe_pkg::NWK))
      rd_val = progk_r[5'(idx_r - fpbe_pkg::IDX_PROGK)];
    else if (idx_r == fpbe_pkg::IDX_ENC)
      rd_val = {30'h0, enc_sel_r};
    else if (idx_r == fpbe_pkg::IDX_STAT)
      rd_val = {29'h0, reserve, eff_sch_r};
    else if (idx_r >= fpbe_pkg::IDX_FUSE0 && idx_r < fpbe_pkg::IDX_FUSE0 + 7'(fpbe_pkg::NW0))
      rd_val = fuse0_r[3'(idx_r - fpbe_pkg::IDX_FUSE0)] &
               ~fpbe_hide0(int'(idx_r - fpbe_pkg::IDX_FUSE0), rmask);
    else if (idx_r >= fpbe_pkg::IDX_FUSEK && idx_r < fpbe_pkg::IDX_FUSEK + 7'(fpbe_pkg::NWK))
    begin
      if (!rmask[2'(int'(idx_r - fpbe_pkg::IDX_FUSEK) / fpbe_pkg::NWB)])
        rd_val = fusek_r[5'(idx_r - fpbe_pkg::IDX_FUSEK)];
    end
    else if (idx_r >= fpbe_pkg::IDX_RAW && idx_r < fpbe_pkg::IDX_RAW + 7'(fpbe_pkg::NWB))
      rd_val = raw_r[3'(idx_r - fpbe_pkg::IDX_RAW)];
    else if (idx_r >= fpbe_pkg::IDX_CODED && idx_r < fpbe_pkg::IDX_CODED + 7'(fpbe_pkg::NWB))
      rd_val = coded[32*int'(idx_r - fpbe_pkg::IDX_CODED) +: 32];
  end

  ////////////////////////////////////////////////////////////////////////////
  // program register writes
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      for (int k = 0; k < fpbe_pkg::NW0; k++)
        prog0_r[k] <= '0;
      for (int k = 0; k < fpbe_pkg::NWK; k++)
        progk_r[k] <= '0;
      for (int k = 0; k < fpbe_pkg::NWB; k++)
        raw_r[k] <= '0;
      enc_sel_r <= '0;
    end
    else if (wr_pend_r)
    begin
      for (int k = 0; k < fpbe_pkg::NW0; k++)
        if (idx_r == fpbe_pkg::IDX_PROG0 + 7'(k))
          prog0_r[k] <= HWDATA;
      for (int k = 0; k < fpbe_pkg::NWK; k++)
        if (idx_r == fpbe_pkg::IDX_PROGK + 7'(k))
          progk_r[k] <= HWDATA;
      for (int k = 0; k < fpbe_pkg::NWB; k++)
        if (idx_r == fpbe_pkg::IDX_RAW + 7'(k))
          raw_r[k] <= HWDATA;
      if (idx_r == fpbe_pkg::IDX_ENC)
        enc_sel_r <= HWDATA[1:0];
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      for (int k = 0; k < fpbe_pkg::NW0; k++)
        fuse0_r[k] <= '0;
      for (int k = 0; k < fpbe_pkg::NWK; k++)
        fusek_r[k] <= '0;
    end
    else if (prog_fire)
    begin
      for (int k = 0; k < fpbe_pkg::NW0; k++)
        fuse0_r[k] <= fuse0_r[k] | (prog0_r[k] & ~fpbe_blk0(k, wmask));
      for (int k = 0; k < fpbe_pkg::NWK; k++)
        fusek_r[k] <= fusek_r[k] | (progk_r[k] & ~fpbe_blkk(k, wmask, reserve));
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      eff_sch_r <= fpbe_pkg::SCH_NONE;
    else if (reserve)
      eff_sch_r <= fpbe_pkg::SCH_34;
    else
      eff_sch_r <= fuse0_r[fpbe_pkg::SCH_WORD][1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // encoder and outputs
  always_comb
  begin
    raw_flat        = '0;
    prog1_flat      = '0;
    KEY_BLOCK_ONE   = '0;
    KEY_BLOCK_TWO   = '0;
    KEY_BLOCK_THREE = '0;
    for (int k = 0; k < fpbe_pkg::NWB; k++)
    begin
      raw_flat[32*k +: 32]        = raw_r[k];
      prog1_flat[32*k +: 32]      = progk_r[k];
      KEY_BLOCK_ONE[32*k +: 32]   = fusek_r[k];
      KEY_BLOCK_TWO[32*k +: 32]   = fusek_r[k + fpbe_pkg::NWB];
      KEY_BLOCK_THREE[32*k +: 32] = fusek_r[k + 2*fpbe_pkg::NWB];
    end
  end

  assign coded = fpbe_encode(raw_flat, eff_sch_r, reserve && (enc_sel_r == 2'h2));

  assign HRDATA       = hrdata_r;
  assign HREADYOUT    = hready_r;
  assign HRESP        = hresp_r;
  assign WR_PROT_MASK = fuse0_r[0][15:0];
  assign RD_PROT_MASK = fuse0_r[0][19:16];
  assign CODING_SEL   = eff_sch_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_word0_keep;
    @(posedge MCLK) disable iff (!RST_N)
    1 |=> (($past(fuse0_r[0]) & ~fuse0_r[0]) == 32'h0);
  endproperty
  a_word0_keep: assert property (p_word0_keep)
    else $error("stored word 0 lost a set bit");

  property p_key1_lock;
    @(posedge MCLK) disable iff (!RST_N)
    prog_fire && wmask[fpbe_pkg::WP_KEY1] |=> $stable(KEY_BLOCK_ONE);
  endproperty
  a_key1_lock: assert property (p_key1_lock)
    else $error("locked key block one changed");

  property p_key1_or;
    @(posedge MCLK) disable iff (!RST_N)
    prog_fire && !wmask[fpbe_pkg::WP_KEY1]
      |=> KEY_BLOCK_ONE == ($past(KEY_BLOCK_ONE) | $past(prog1_flat));
  endproperty
  a_key1_or: assert property (p_key1_or)
    else $error("key block one not ored with program data");

  property p_mask_self;
    @(posedge MCLK) disable iff (!RST_N)
    prog_fire && wmask[fpbe_pkg::WP_WRMASK] |=> $stable(WR_PROT_MASK);
  endproperty
  a_mask_self: assert property (p_mask_self)
    else $error("locked write mask changed");

  // read mask programmed from word 0
  property p_rdm_map;
    @(posedge MCLK) disable iff (!RST_N)
    prog_fire && (wmask == 16'h0000)
      |=> RD_PROT_MASK == ($past(RD_PROT_MASK) | $past(prog_rdm));
  endproperty
  a_rdm_map: assert property (p_rdm_map)
    else $error("read mask not taken from word 0 bits 19:16");

  property p_rd_hide;
    @(posedge MCLK) disable iff (!RST_N)
    rd_pend_r && (idx_r == fpbe_pkg::IDX_FUSEK) && rmask[0] |=> HRDATA == 32'h0;
  endproperty
  a_rd_hide: assert property (p_rd_hide)
    else $error("read-protected key block visible");

  property p_rd_wait;
    @(posedge MCLK) disable iff (!RST_N)
    acc && !HWRITE |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read answer timing wrong");

  // reserve forces 3/4 and holds block three bits 191:128
  property p_res_sch;
    @(posedge MCLK) disable iff (!RST_N)
    reserve && prog_fire |=> CODING_SEL == fpbe_pkg::SCH_34 &&
                            $stable(KEY_BLOCK_THREE[191:128]);
  endproperty
  a_res_sch: assert property (p_res_sch)
    else $error("reserve flag not honoured");

  property p_none;
    @(posedge MCLK) disable iff (!RST_N)
    eff_sch_r == fpbe_pkg::SCH_NONE |-> coded == raw_flat;
  endproperty
  a_none: assert property (p_none)
    else $error("no-coding image differs from block");

  property p_rep;
    @(posedge MCLK) disable iff (!RST_N)
    eff_sch_r == fpbe_pkg::SCH_REPEAT
      |-> coded[255:128] == raw_flat[127:0] && coded[127:0] == raw_flat[127:0];
  endproperty
  a_rep: assert property (p_rep)
    else $error("repeat image halves wrong");

  property p_xor;
    @(posedge MCLK) disable iff (!RST_N)
    eff_sch_r == fpbe_pkg::SCH_34 |-> coded[55:48] == (raw_flat[7:0] ^ raw_flat[15:8] ^
      raw_flat[23:16] ^ raw_flat[31:24] ^ raw_flat[39:32] ^ raw_flat[47:40]);
  endproperty
  a_xor: assert property (p_xor)
    else $error("3/4 xor byte wrong");

endmodule : fpbe_top

// *** hdl/fpbe_pkg.sv ***
// constants for the fuse protect and block encode logic
package fpbe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register word indices, byte address is four times the index
  localparam logic [6:0] IDX_PROG0 = 7'h00;
  localparam logic [6:0] IDX_PROGK = 7'h08;
  localparam logic [6:0] IDX_CMD   = 7'h20;
  localparam logic [6:0] IDX_ENC   = 7'h21;
  localparam logic [6:0] IDX_STAT  = 7'h22;
  localparam logic [6:0] IDX_FUSE0 = 7'h40;
  localparam logic [6:0] IDX_FUSEK = 7'h48;
  localparam logic [6:0] IDX_RAW   = 7'h60;
  localparam logic [6:0] IDX_CODED = 7'h68;

  // word counts of each bank
  localparam int NW0  = 7;
  localparam int NWB  = 8;
  localparam int NWK  = 24;

  // command bit
  localparam int CMD_PROG_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // write-protect mask bit for each field group
  localparam int WP_RDMASK = 0;
  localparam int WP_WRMASK = 1;
  localparam int WP_CNT    = 2;
  localparam int WP_MISC   = 3;
  localparam int WP_CLK8   = 4;
  localparam int WP_REG    = 5;
  localparam int WP_PAD    = 6;
  localparam int WP_KEY1   = 7;
  localparam int WP_CODE   = 10;
  localparam int WP_SB0    = 12;
  localparam int WP_SB1    = 13;
  localparam int WP_JTAG   = 14;
  localparam int WP_DBG    = 15;
  localparam int WP_DLDIS  = 2;

  // read-protect mask bit guarding the configuration fields
  localparam int RP_CFG    = 3;

  // field positions in the stored image words
  localparam int RES_WORD  = 3;
  localparam int RES_BIT   = 14;
  localparam int SCH_WORD  = 6;

  ////////////////////////////////////////////////////////////////////////////
  // block encoding selector codes
  localparam logic [1:0] SCH_NONE   = 2'h0;
  localparam logic [1:0] SCH_34     = 2'h1;
  localparam logic [1:0] SCH_REPEAT = 2'h2;

  // 3/4 coding geometry
  localparam int N_GRP     = 4;
  localparam int N_DBYTE   = 6;
  localparam int BYTE_W    = 8;
  localparam int GRP_DBITS = 48;
  localparam int GRP_IBITS = 64;
  localparam int XOR_BYTE  = 6;
  localparam int SUM_BYTE  = 7;

endpackage : fpbe_pkg

// *** tb/fpbe_consumer.sv ***
// hardware consumer model of the stored key block one
`timescale 1ns/1ps

module fpbe_consumer (
  // clock
  input  wire logic         clk,
  // stored key image
  input  wire logic [255:0] key_one,
  // snapshot seen by hardware
  output logic      [31:0]  key_word0
);

  ////////////////////////////////////////////////////////////////////////////
  // hardware still sees key
  always_ff @(posedge clk)
  begin
    key_word0 <= key_one[31:0];
  end

endmodule : fpbe_consumer

// *** tb/tb.sv ***
// self-checking bench for the fuse protect and block encode logic
`timescale 1ns/1ps

module tb;

  ////////////////////////////////////////////////////////////////////////////
  // signals
  logic         mclk;
  logic         rst_n;
  logic         hsel;
  logic [8:0]   haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  logic [255:0] key_one;
  logic [255:0] key_two;
  logic [255:0] key_three;
  logic [15:0]  wr_mask;
  logic [3:0]   rd_mask;
  logic [1:0]   coding_sel;
  logic [31:0]  seen_key;
  logic [255:0] raw;
  int           failures;
  int           num_checks;
  int           cyc = 0;

  fpbe_top DUT (
    .MCLK(mclk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .KEY_BLOCK_ONE(key_one), .KEY_BLOCK_TWO(key_two), .KEY_BLOCK_THREE(key_three),
    .WR_PROT_MASK(wr_mask), .RD_PROT_MASK(rd_mask), .CODING_SEL(coding_sel)
  );

  fpbe_consumer partner (
    .clk(mclk), .key_one(key_one), .key_word0(seen_key)
  );

  always #2.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  // report
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      failures++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite master, entered right after a rising edge
  task automatic waitr(output logic [31:0] rd);
    int n;
    n = 0;
    @(negedge mclk);
    while (hreadyout !== 1'b1 && n < 20)
    begin
      n++;
      @(negedge mclk);
    end
    if (n == 20)
      failures++;
    rd = hrdata;
    @(posedge mclk);
  endtask : waitr

  task automatic ahb(input logic [6:0] idx, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {idx, 2'b00};
    hwrite <= w;
    waitr(rd);
    htrans <= 2'h0;
    hwdata <= wd;
    waitr(rd);
  endtask : ahb

  task automatic wr(input logic [6:0] idx, input logic [31:0] d);
    logic [31:0] v;
    ahb(idx, 1'b1, d, v);
  endtask : wr

  task automatic rdc(input logic [6:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    ahb(idx, 1'b0, 32'h0, v);
    check(v, exp);
  endtask : rdc

  task automatic prog();
    wr(fpbe_pkg::IDX_CMD, 32'h1 << fpbe_pkg::CMD_PROG_BIT);
    @(posedge mclk);
  endtask : prog

  ////////////////////////////////////////////////////////////////////////////
  // expected stored image of a key block
  function automatic logic [255:0] enc(input logic [255:0] r, input logic [1:0] s);
    logic [255:0] e;
    logic [7:0]   x;
    logic [7:0]   sm;
    logic [7:0]   b;
    e = r;
    if (s == fpbe_pkg::SCH_REPEAT)
      e = {r[127:0], r[127:0]};
    if (s == fpbe_pkg::SCH_34)
    begin
      e = '0;
      for (int i = 0; i < 4; i++)
      begin
        x = 8'h00;
        sm = 8'h00;
        for (int j = 0; j < 6; j++)
        begin
          b = r[48*i+8*j +: 8];
          e[64*i+8*j +: 8] = b;
          x = x ^ b;
          sm = sm + 8'((j + 1) * $countones(b));
        end
        e[64*i+48 +: 8] = x;
        e[64*i+56 +: 8] = sm;
      end
    end
    return e;
  endfunction : enc

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rdc(fpbe_pkg::IDX_PROG0, 32'h0);                   // program word reset
    rdc(fpbe_pkg::IDX_FUSE0, 32'h0);                   // blank storage
    rdc(7'h30, 32'h0);                                 // unmapped word
    @(negedge mclk);
    check(32'({hresp, coding_sel, wr_mask}), 32'h0);   // reset outputs
    @(posedge mclk);
  endtask : t_reset

  task automatic t_program();
    wr(fpbe_pkg::IDX_PROG0 + 7'h1, 32'h1234_5678);
    wr(fpbe_pkg::IDX_PROG0, 32'h0050_0000);
    wr(fpbe_pkg::IDX_PROGK, 32'hA5A5_A5A5);
    rdc(fpbe_pkg::IDX_PROG0 + 7'h1, 32'h1234_5678);    // program word readback
    prog();
    rdc(fpbe_pkg::IDX_FUSE0 + 7'h1, 32'h1234_5678);    // bits set
    rdc(fpbe_pkg::IDX_FUSE0, 32'h0050_0000);           // counter field
    wr(fpbe_pkg::IDX_PROG0 + 7'h1, 32'h0000_0001);
    wr(fpbe_pkg::IDX_PROG0, 32'h0);
    prog();
    rdc(fpbe_pkg::IDX_FUSE0 + 7'h1, 32'h1234_5679);    // ones stay one
  endtask : t_program

  task automatic t_wprot();
    wr(fpbe_pkg::IDX_PROG0, 32'h1 << fpbe_pkg::WP_MISC);
    prog();
    @(negedge mclk);
    check(32'(wr_mask), 32'h0008);                     // mask output
    @(posedge mclk);
    wr(fpbe_pkg::IDX_PROG0 + 7'h1, 32'hFFFF_FFFF);
    prog();
    rdc(fpbe_pkg::IDX_FUSE0 + 7'h1, 32'h1234_5679);    // locked word unchanged
    wr(fpbe_pkg::IDX_PROG0, (32'h1 << fpbe_pkg::WP_WRMASK) | (32'h1 << fpbe_pkg::WP_KEY1));
    prog();
    wr(fpbe_pkg::IDX_PROG0, 32'h1 << fpbe_pkg::WP_CLK8);
    wr(fpbe_pkg::IDX_PROG0 + 7'h4, 32'h0000_00FF);
    prog();
    rdc(fpbe_pkg::IDX_FUSE0, 32'h0050_008A);           // mask locks itself
    rdc(fpbe_pkg::IDX_FUSE0 + 7'h4, 32'h0000_00FF);    // unlocked word writable
    rdc(fpbe_pkg::IDX_FUSE0 + 7'h1, 32'h1234_5679);    // still locked
  endtask : t_wprot

  task automatic t_rprot();
    wr(fpbe_pkg::IDX_PROGK, 32'hFFFF_FFFF);
    wr(fpbe_pkg::IDX_PROGK + 7'h8, 32'h5A5A_5A5A);
    prog();
    rdc(fpbe_pkg::IDX_FUSEK, 32'hA5A5_A5A5);           // locked, readable
    wr(fpbe_pkg::IDX_PROG0, 32'h0001_0000);
    prog();
    rdc(fpbe_pkg::IDX_FUSEK, 32'h0);                   // software read denied
    rdc(fpbe_pkg::IDX_FUSEK + 7'h8, 32'h5A5A_5A5A);    // other block open
    rdc(fpbe_pkg::IDX_FUSE0 + 7'h1, 32'h1234_5679);    // unguarded readable
    @(negedge mclk);
    check(seen_key, 32'hA5A5_A5A5);                    // hardware still sees
    check(32'(rd_mask), 32'h1);                        // guard bit zero
    check(key_two[31:0], 32'h5A5A_5A5A);               // block two port
    @(posedge mclk);
    wr(fpbe_pkg::IDX_PROG0, 32'h0);
    prog();
    rdc(fpbe_pkg::IDX_FUSEK, 32'h0);                   // guard persists
  endtask : t_rprot

  task automatic chk_code(input logic [1:0] s, input logic z);
    logic [255:0] e;
    @(negedge mclk);
    check(32'(coding_sel), 32'(s));                    // effective selector
    @(posedge mclk);
    e = enc(raw, s);
    if (z)
      e[191:128] = '0;
    for (int k = 0; k < 8; k++)
      rdc(7'(fpbe_pkg::IDX_CODED + k), e[32*k +: 32]); // coded words
  endtask : chk_code

  task automatic t_code();
    for (int k = 0; k < 8; k++)
    begin
      raw[32*k +: 32] = 32'(32'h1357_9BDF + 32'h2468_ACE1 * k);
      wr(7'(fpbe_pkg::IDX_RAW + k), raw[32*k +: 32]);  // raw input
    end
    chk_code(2'h0, 1'b0);
    wr(fpbe_pkg::IDX_PROG0 + 7'h6, 32'h2);
    prog();
    chk_code(2'h2, 1'b0);                              // free selector
    wr(fpbe_pkg::IDX_PROG0 + 7'h6, 32'h1);
    prog();
    chk_code(2'h3, 1'b0);
    wr(fpbe_pkg::IDX_PROG0 + 7'h3, 32'h1 << fpbe_pkg::RES_BIT);
    wr(fpbe_pkg::IDX_PROGK + 7'd19, 32'hCAFE_0003);
    prog();
    chk_code(2'h1, 1'b0);                              // forced 3/4
    rdc(fpbe_pkg::IDX_STAT, 32'h5);                    // reserve status
    wr(fpbe_pkg::IDX_ENC, 32'h2);
    chk_code(2'h1, 1'b1);                              // hidden image part
    wr(fpbe_pkg::IDX_PROGK + 7'd20, 32'hFFFF_FFFF);
    prog();
    rdc(fpbe_pkg::IDX_FUSEK + 7'd19, 32'hCAFE_0003);   // block three word 3
    rdc(fpbe_pkg::IDX_FUSEK + 7'd20, 32'h0);           // unavailable word
    @(negedge mclk);
    check(key_three[159:128], 32'h0);                  // port image
    @(posedge mclk);
  endtask : t_code

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 9'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    raw = '0;
    failures = 0;
    num_checks = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_program();
    t_wprot();
    t_rprot();
    t_code();
    finish_test();
  end

endmodule : tb
